// [verilog/hsd_pkg.sv]
// constants for the hall signal processing chain: register map, field
// positions, reset values, timing and the low-pass coefficient table.
// assumes a 100 MHz pclk and a 32-bit apb register bus.
package hsd_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned FILT_RATE_HZ    = 16_000;
	localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / FILT_RATE_HZ;
	localparam int unsigned DIV_W           = 13;
	// ****************************************************************
	// register byte addresses
	// ****************************************************************
	localparam logic [7:0] ADDR_GAIN   = 8'h00;
	localparam logic [7:0] ADDR_OFFS   = 8'h04;
	localparam logic [7:0] ADDR_FILT   = 8'h08;
	localparam logic [7:0] ADDR_RANGE  = 8'h0c;
	localparam logic [7:0] ADDR_LIMIT  = 8'h10;
	localparam logic [7:0] ADDR_TC1    = 8'h14;
	localparam logic [7:0] ADDR_TC2    = 8'h18;
	localparam logic [7:0] ADDR_TREF   = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int unsigned DYN_BIT      = 4;
	localparam int unsigned HI_LSB       = 8;
	localparam int unsigned STAT_RNG_LSB = 16;
	localparam logic [14:0] GAIN_RST   = 15'h5000;
	localparam logic [14:0] OFFS_RST   = 15'h4000;
	localparam logic [2:0]  FILT_RST   = 3'h3;
	localparam logic [1:0]  RANGE_RST  = 2'h1;
	localparam logic [5:0]  LO_RST     = 6'h00;
	localparam logic [5:0]  HI_RST     = 6'h3f;
	localparam logic [8:0]  TL_RST     = 9'h0a0;
	localparam logic [7:0]  TQ_RST     = 8'h80;
	localparam logic [7:0]  TREF_RST   = 8'h00;
	// ****************************************************************
	// arithmetic constants
	// ****************************************************************
	localparam logic signed [15:0] CODE_MID  = 16'sh4000;
	localparam logic signed [9:0]  TL_MID    = 10'sh0a0;
	localparam logic signed [8:0]  TQ_MID    = 9'sh080;
	localparam logic signed [27:0] S_ONE     = 28'sh0800000;
	localparam int unsigned        S_FRAC    = 23;
	localparam int unsigned        LIN_SHIFT = 7;
	localparam int unsigned        G_FRAC    = 12;
	localparam int unsigned        A_FRAC    = 16;
	localparam logic [2:0]  FILT_OFF   = 3'h7;
	localparam logic [1:0]  RANGE_LOW  = 2'h3;
	localparam logic [1:0]  RANGE_MID  = 2'h1;
	localparam logic [1:0]  RANGE_NONE = 2'h2;
	localparam logic [5:0]  LO_OFF     = 6'h00;
	localparam logic [5:0]  HI_OFF     = 6'h3f;
	localparam int unsigned LIM_SHIFT  = 10;
	localparam logic [15:0] OUT_MAX    = 16'hffff;
	localparam int unsigned FIFO_DEPTH = 16;

	// smoothing weight per filter code, fraction of 2^16 per 16 kHz step
	function automatic logic [16:0] lp_alpha(input logic [2:0] code);
		case (code)
			3'h0: lp_alpha = 17'h0080b;
			3'h1: lp_alpha = 17'h01821;
			3'h2: lp_alpha = 17'h02c3c;
			3'h3: lp_alpha = 17'h04057;
			3'h4: lp_alpha = 17'h05675;
			3'h5: lp_alpha = 17'h06e96;
			3'h6: lp_alpha = 17'h08bbd;
			default: lp_alpha = 17'h10000;
		endcase
	endfunction : lp_alpha
endpackage : hsd_pkg

// [verilog/hsd_chain.sv]
// hall field processing chain: filter, gain with temperature factor,
// offset, 16-bit limiter, clamping, then an output fifo to the protocol
// stage. assumes one 100 MHz clock and inputs synchronous to it.
//
// How it works
// - range codes 3,1,0 pick low, mid, high
// - range code 2 behaves as code 1
// - dynamic mode takes range from master input
// - every range stays symmetric about zero field
// - order: filter, multiply, offset, 16-bit limit
// - temp factor: linear plus quadratic, times gain
// - gain equals (code minus 16384) over 4096
// - offset equals code minus 16384
// - filter codes 0..6 select seven cutoffs
// - filter code 7 bypasses the filter
// - filter keeps unity gain at dc
// - filtered samples update at 16 kHz
// - low clamp is code times 1024
// - high clamp is (code+1) times 1024 minus 1
// - output limited to active clamp values
// - high clamp wins over low clamp
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps

// ********************************************************************
// output fifo
// ********************************************************************
module hsd_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned PW = $clog2(DEPTH);
	localparam int unsigned CW = PW + 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage words
		logic [PW-1:0]               wptr;  // next write slot
		logic [PW-1:0]               rptr;  // oldest word
		logic [CW-1:0]               count; // words held
		logic                        full;  // no room left
		logic                        avail; // at least one word
		logic [WIDTH-1:0]            head;  // copy of the oldest word
	} hsd_fifo_type;

	hsd_fifo_type st_r;
	hsd_fifo_type st_nxt;

	// flags are registered so both handshakes leave from flip-flops
	always_comb begin
		logic push;
		logic pop;
		push = in_valid & ~st_r.full;
		pop = st_r.avail & out_ready;
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wptr] = in_data;
			st_nxt.wptr = PW'(st_r.wptr + 1'b1);
		end
		if (pop) begin
			st_nxt.rptr = PW'(st_r.rptr + 1'b1);
		end
		st_nxt.head = st_nxt.mem[st_nxt.rptr]; // output word leaves a flop
		st_nxt.count = CW'(st_r.count + CW'(push) - CW'(pop));
		st_nxt.full = (st_nxt.count == CW'(DEPTH));
		st_nxt.avail = (st_nxt.count != '0);
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign in_ready = ~st_r.full;
	assign out_valid = st_r.avail;
	assign out_data = st_r.head;
endmodule : hsd_fifo

// ********************************************************************
// processing chain with apb registers
// ********************************************************************
module hsd_chain #(
	parameter int unsigned TICK_CYCLES = hsd_pkg::TICK_CYCLES_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] field_sample,
	input  wire logic        field_valid,
	input  wire logic [7:0]  temp_sample,
	input  wire logic [1:0]  dyn_range_code,
	output logic [1:0]       range_select,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [15:0]      out_data
);
	typedef struct packed {
		logic [14:0] gain;      // gain_code
		logic [14:0] offs;      // offset_code
		logic [2:0]  lp;        // filter_bandwidth_select
		logic [1:0]  range;     // field_range_select
		logic        dyn;       // dynamic range mode
		logic [5:0]  lo;        // lower_limit_code
		logic [5:0]  hi;        // upper_limit_code
		logic [8:0]  tl;        // linear_temp_coeff
		logic [7:0]  tq;        // quadratic_temp_coeff
		logic [7:0]  t0;        // reference_temperature
		logic [hsd_pkg::DIV_W-1:0] div; // rate divider
		logic [15:0] x_hold;    // newest converter sample
		logic [31:0] filt;      // filter state, 16 fraction bits
		logic        s1_v;      // stage 1: filtered sample
		logic [15:0] s1_x;
		logic [27:0] s1_s;      // temperature factor
		logic        s2_v;      // stage 2: combined factor
		logic [15:0] s2_x;
		logic [23:0] s2_g;
		logic        s3_v;      // stage 3: limited, clamped word
		logic [15:0] s3_d;
		logic [15:0] last;      // last word handed to the fifo
		logic [1:0]  rsel;      // converter range in use
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} hsd_state_type;

	hsd_state_type st_r;
	hsd_state_type st_nxt;
	logic          fifo_in_ready;

	// limiter: negative to zero, beyond 16 bits to all ones
	function automatic logic [15:0] sat16(input logic signed [28:0] v);
		if (v < 0) begin
			sat16 = '0;
		end else if (v > $signed({13'h0, hsd_pkg::OUT_MAX})) begin
			sat16 = hsd_pkg::OUT_MAX;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		logic               adv;
		logic               tick;
		logic        [1:0]  eff;
		logic signed [32:0] diff;
		logic signed [50:0] fprod;
		logic signed [32:0] nf;
		logic signed [8:0]  dt;
		logic signed [9:0]  c1;
		logic signed [8:0]  c2;
		logic signed [18:0] lin;
		logic signed [17:0] sq;
		logic signed [26:0] quad;
		logic signed [27:0] sfac;
		logic signed [15:0] gs;
		logic signed [43:0] gprod;
		logic signed [39:0] xprod;
		logic signed [28:0] sum;
		logic        [15:0] lim;
		logic        [15:0] lo_v;
		logic        [15:0] hi_v;
		logic               setup;
		logic               acc;
		logic        [31:0] rd;
		logic               err;
		adv = '0;
		tick = '0;
		eff = '0;
		diff = '0;
		fprod = '0;
		nf = '0;
		dt = '0;
		c1 = '0;
		c2 = '0;
		lin = '0;
		sq = '0;
		quad = '0;
		sfac = '0;
		gs = '0;
		gprod = '0;
		xprod = '0;
		sum = '0;
		lim = '0;
		lo_v = '0;
		hi_v = '0;
		rd = '0;
		err = '0;
		st_nxt = st_r;
		// converter range, stored or supplied by the master
		eff = st_r.dyn ? dyn_range_code : st_r.range;
		// the span only scales; the converter stays centred on zero
		// field for every code
		if (eff == hsd_pkg::RANGE_NONE) begin
			eff = hsd_pkg::RANGE_MID;
		end
		st_nxt.rsel = eff;

		// newest converter sample is held until the next filter step
		if (field_valid) begin
			st_nxt.x_hold = field_sample;
		end

		// pipeline moves unless the last stage waits on a full fifo;
		// a tick lost to back-pressure drops that filter step
		adv = ~st_r.s3_v | fifo_in_ready;

		// 16 kHz step enable
		if (st_r.div == hsd_pkg::DIV_W'(TICK_CYCLES - 1)) begin
			st_nxt.div = '0;
			tick = 1'b1;
		end else begin
			st_nxt.div = hsd_pkg::DIV_W'(st_r.div + 1'b1);
		end

		// ------ stage 1: low-pass filter and temperature factor ------
		// first-order smoother y += a*(x-y); the floor shift leaves a rising y a fraction of an LSB below x
		diff = $signed({st_r.x_hold[15], st_r.x_hold, 16'h0})
			- $signed({st_r.filt[31], st_r.filt});
		fprod = diff * $signed({1'b0, hsd_pkg::lp_alpha(st_r.lp)});
		nf = $signed({st_r.filt[31], st_r.filt})
			+ 33'(fprod >>> hsd_pkg::A_FRAC);
		if (st_r.lp == hsd_pkg::FILT_OFF) begin
			nf = $signed({st_r.x_hold[15], st_r.x_hold, 16'h0});
		end
		// temperature minus reference, then linear and square paths
		dt = $signed({temp_sample[7], temp_sample})
			- $signed({st_r.t0[7], st_r.t0});
		c1 = $signed({1'b0, st_r.tl}) - hsd_pkg::TL_MID;
		c2 = $signed({1'b0, st_r.tq}) - hsd_pkg::TQ_MID;
		lin = c1 * dt;
		sq = dt * dt;
		quad = c2 * sq;
		sfac = hsd_pkg::S_ONE
			+ (28'(lin) <<< hsd_pkg::LIN_SHIFT) + 28'(quad);
		if (adv) begin
			st_nxt.s1_v = '0;
			if (tick) begin
				st_nxt.filt = nf[31:0];
				st_nxt.s1_x = nf[31:16];
				st_nxt.s1_s = sfac;
				st_nxt.s1_v = 1'b1;
			end
		end

		// ------ stage 2: factor times signed gain ------
		gs = $signed({1'b0, st_r.gain}) - hsd_pkg::CODE_MID;
		gprod = gs * $signed(st_r.s1_s);
		if (adv) begin
			st_nxt.s2_v = st_r.s1_v;
			st_nxt.s2_x = st_r.s1_x;
			st_nxt.s2_g = 24'(gprod >>> hsd_pkg::S_FRAC);
		end

		// ------ stage 3: multiply, offset, limit, clamp ------
		xprod = $signed(st_r.s2_x) * $signed(st_r.s2_g);
		sum = 29'(xprod >>> hsd_pkg::G_FRAC)
			+ 29'($signed({1'b0, st_r.offs}) - hsd_pkg::CODE_MID);
		lim = sat16(sum);
		lo_v = 16'({st_r.lo, 10'h0});
		hi_v = 16'({st_r.hi, 10'h3ff});
		// low first, high last, so a crossed pair leaves the high
		// value standing whatever the field
		if (st_r.lo != hsd_pkg::LO_OFF && lim < lo_v) begin
			lim = lo_v;
		end
		if (st_r.hi != hsd_pkg::HI_OFF && lim > hi_v) begin
			lim = hi_v;
		end
		if (st_r.s3_v && fifo_in_ready) begin
			st_nxt.last = st_r.s3_d;
		end
		if (adv) begin
			st_nxt.s3_v = st_r.s2_v;
			st_nxt.s3_d = lim;
		end

		// ------ apb slave: decode in setup, finish in access ------
		setup = psel & ~penable;
		acc = psel & penable & st_r.pready;
		if (paddr == hsd_pkg::ADDR_GAIN) begin
			rd = {17'h0, st_r.gain};
		end else if (paddr == hsd_pkg::ADDR_OFFS) begin
			rd = {17'h0, st_r.offs};
		end else if (paddr == hsd_pkg::ADDR_FILT) begin
			rd = {29'h0, st_r.lp};
		end else if (paddr == hsd_pkg::ADDR_RANGE) begin
			rd = {27'h0, st_r.dyn, 2'h0, st_r.range};
		end else if (paddr == hsd_pkg::ADDR_LIMIT) begin
			rd = {18'h0, st_r.hi, 2'h0, st_r.lo};
		end else if (paddr == hsd_pkg::ADDR_TC1) begin
			rd = {23'h0, st_r.tl};
		end else if (paddr == hsd_pkg::ADDR_TC2) begin
			rd = {24'h0, st_r.tq};
		end else if (paddr == hsd_pkg::ADDR_TREF) begin
			rd = {24'h0, st_r.t0};
		end else if (paddr == hsd_pkg::ADDR_STATUS) begin
			rd = {14'h0, st_r.rsel, st_r.last};
		end else begin
			err = 1'b1; // unmapped: error, reads zero
		end
		if (setup) begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = err;
			st_nxt.prdata = pwrite ? '0 : rd;
		end else begin
			st_nxt.pready = '0;
			st_nxt.pslverr = '0;
		end
		// writes land on the completing edge only
		if (acc && pwrite && !st_r.pslverr) begin
			if (paddr == hsd_pkg::ADDR_GAIN) begin
				st_nxt.gain = pwdata[14:0];
			end else if (paddr == hsd_pkg::ADDR_OFFS) begin
				st_nxt.offs = pwdata[14:0];
			end else if (paddr == hsd_pkg::ADDR_FILT) begin
				st_nxt.lp = pwdata[2:0];
			end else if (paddr == hsd_pkg::ADDR_RANGE) begin
				st_nxt.range = pwdata[1:0];
				st_nxt.dyn = pwdata[hsd_pkg::DYN_BIT];
			end else if (paddr == hsd_pkg::ADDR_LIMIT) begin
				st_nxt.lo = pwdata[5:0];
				st_nxt.hi = pwdata[hsd_pkg::HI_LSB +: 6];
			end else if (paddr == hsd_pkg::ADDR_TC1) begin
				st_nxt.tl = pwdata[8:0];
			end else if (paddr == hsd_pkg::ADDR_TC2) begin
				st_nxt.tq = pwdata[7:0];
			end else if (paddr == hsd_pkg::ADDR_TREF) begin
				st_nxt.t0 = pwdata[7:0];
			end
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.gain <= hsd_pkg::GAIN_RST;
			st_r.offs <= hsd_pkg::OFFS_RST;
			st_r.lp <= hsd_pkg::FILT_RST;
			st_r.range <= hsd_pkg::RANGE_RST;
			st_r.lo <= hsd_pkg::LO_RST;
			st_r.hi <= hsd_pkg::HI_RST;
			st_r.tl <= hsd_pkg::TL_RST;
			st_r.tq <= hsd_pkg::TQ_RST;
			st_r.t0 <= hsd_pkg::TREF_RST;
			st_r.rsel <= hsd_pkg::RANGE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// output fifo towards the protocol stage
	// ****************************************************************
	hsd_fifo #(
		.WIDTH (16),
		.DEPTH (hsd_pkg::FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (st_r.s3_v),
		.in_ready  (fifo_in_ready),
		.in_data   (st_r.s3_d),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_data)
	);

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign range_select = st_r.rsel;
endmodule : hsd_chain

// [bench/hsd_chain_chk.sv]
// checks on the hall chain ports: apb answer timing, range mapping,
// output hold and clamp limits; bound to hsd_chain, sees only its ports.
`timescale 1ns/1ps
module hsd_chain_chk #(
	parameter int unsigned TICK_CYCLES = hsd_pkg::TICK_CYCLES_DEF
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [15:0] field_sample,
	input wire logic        field_valid,
	input wire logic [7:0]  temp_sample,
	input wire logic [1:0]  dyn_range_code,
	input wire logic [1:0]  range_select,
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic [15:0] out_data
);
	// ****************************************************************
	// shadow of the programmed codes
	// ****************************************************************
	logic [4:0]  n_r;   // words taken since the last limit write
	logic [5:0]  lo_r;  // low limit code
	logic [5:0]  hi_r;  // high limit code
	logic [1:0]  rng_r; // stored range code
	logic        dyn_r; // dynamic range mode
	logic [15:0] age_r; // cycles since reset, saturating
	logic        hs;    // word handed over
	logic        wr;    // apb write commit
	logic [1:0]  want;  // range the converter should get
	assign hs = out_valid && out_ready;
	assign wr = psel && penable && pready && pwrite;
	assign want = dyn_r ? dyn_range_code : rng_r;
	// up to 17 older words may still be queued when limits change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_r   <= 5'h00;
			lo_r  <= hsd_pkg::LO_RST;
			hi_r  <= hsd_pkg::HI_RST;
			rng_r <= hsd_pkg::RANGE_RST;
			dyn_r <= 1'b0;
			age_r <= 16'h0000;
		end else begin
			if (age_r != 16'hffff) begin
				age_r <= age_r + 16'h0001;
			end
			if (wr && paddr == hsd_pkg::ADDR_LIMIT) begin
				lo_r <= pwdata[5:0];
				hi_r <= pwdata[13:8];
				n_r  <= 5'h00;
			end else if (hs && n_r != 5'h14) begin
				n_r <= n_r + 5'h01;
			end
			if (wr && paddr == hsd_pkg::ADDR_RANGE) begin
				rng_r <= pwdata[1:0];
				dyn_r <= pwdata[hsd_pkg::DYN_BIT];
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************************************
	// assertions
	// ****************************************************************
	chk_pready_next: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	chk_pready_once: assert property (pready |=> !pready)
		else $error("pready held");
	chk_err_unmapped: assert property (
		psel && !penable && paddr > hsd_pkg::ADDR_STATUS |=> pslverr)
		else $error("unmapped access not refused");
	chk_range_map: assert property (
		$stable(want) [*3] |-> range_select == (want == 2'h2 ? 2'h1 : want))
		else $error("range select wrong");
	chk_out_hold: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("word lost while stalled");
	chk_lo_clamp: assert property (
		hs && n_r == 5'h14 && lo_r <= hi_r |-> out_data >= {lo_r, 10'h000})
		else $error("word below low limit");
	chk_hi_clamp: assert property (
		hs && n_r == 5'h14 |-> out_data <= {hi_r, 10'h3ff})
		else $error("word above high limit");
	chk_limit_cross: assert property (
		hs && n_r == 5'h14 && lo_r > hi_r |-> out_data == {hi_r, 10'h3ff})
		else $error("crossed limits not high value");
	chk_first_word: assert property (
		out_valid |-> age_r >= TICK_CYCLES)
		else $error("word before first filter step");
	cover property (hs && out_data == 16'hffff);
	cover property (pslverr);
	cover property (hs && lo_r > hi_r);
	cover property (out_valid && !out_ready);
endmodule : hsd_chain_chk
bind hsd_chain hsd_chain_chk #(.TICK_CYCLES(TICK_CYCLES)) hsd_chain_chk_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .field_sample(field_sample),
	.field_valid(field_valid), .temp_sample(temp_sample),
	.dyn_range_code(dyn_range_code), .range_select(range_select),
	.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

// [bench/hsd_far_side.sv]
// far side model: field converter feeding samples and the protocol
// stage taking words; the test steers it through its control ports.
`timescale 1ns/1ps
module hsd_far_side (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [15:0] smp,            // field value to convert
	input wire logic [7:0]  tmp,            // temperature to present
	input wire logic [1:0]  dyn,            // run-time range request
	input wire logic        stall,          // protocol stage busy
	output logic [15:0]     field_sample,
	output logic            field_valid,
	output logic [7:0]      temp_sample,
	output logic [1:0]      dyn_range_code,
	input wire logic        out_valid,
	output logic            out_ready,
	input wire logic [15:0] out_data,
	output logic [15:0]     last_word,      // last word taken
	output logic [31:0]     word_cnt,       // words taken
	output logic [15:0]     gap             // cycles between two words
);
	logic [1:0]  ph_r;  // conversion phase, one sample per 4 cycles
	logic [15:0] run_r; // cycles since the last word taken
	assign temp_sample = tmp;
	assign dyn_range_code = dyn;
	assign out_ready = !stall;
	// between conversions the data toggles, so a stale capture shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_r <= 2'h0;
			field_valid <= 1'b0;
			field_sample <= 16'h0000;
			last_word <= 16'h0000;
			word_cnt <= 32'h0;
			gap <= 16'h0000;
			run_r <= 16'h0000;
		end else begin
			ph_r <= ph_r + 2'h1;
			field_valid <= ph_r == 2'h3;
			field_sample <= ph_r == 2'h3 ? smp : ~field_sample;
			run_r <= run_r + 16'h0001;
			if (out_valid && out_ready) begin
				last_word <= out_data;
				word_cnt <= word_cnt + 32'h1;
				gap <= run_r + 16'h0001;
				run_r <= 16'h0000;
			end
		end
	end
endmodule : hsd_far_side

// [bench/test_hsd_chain.sv]
// self-checking bench for hsd_chain: apb register access, range
// selection, arithmetic cases, filter steps and output buffering.
`timescale 1ns/1ps
module test_hsd_chain;
	localparam int unsigned TICK = 20; // short filter period
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, e, pready, pslverr, field_valid, out_valid;
	logic [7:0] paddr = 8'h00, temp_sample, tmp = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, cnt, word_cnt;
	logic [15:0] field_sample, out_data, smp = 16'h0, last_word, gap, y;
	logic [1:0] dyn_range_code, range_select, dyn = 2'h0;
	logic out_ready, stall = 1'b0;
	int error_cnt = 0, num_checks = 0, cyc = 0;
	int fc[8] = '{80, 240, 440, 640, 860, 1100, 1390, 0};
	logic [31:0] rv[8] = '{32'h5000, 32'h4000, 32'h3, 32'h1, 32'h3f00,
		32'ha0, 32'h80, 32'h0}; // register defaults
	always #5 pclk = ~pclk;
	hsd_chain #(.TICK_CYCLES(TICK)) hsd_chain_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .field_sample(field_sample),
		.field_valid(field_valid), .temp_sample(temp_sample),
		.dyn_range_code(dyn_range_code), .range_select(range_select),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
	hsd_far_side hsd_far_side_inst (
		.pclk(pclk), .presetn(presetn), .smp(smp), .tmp(tmp), .dyn(dyn),
		.stall(stall), .field_sample(field_sample),
		.field_valid(field_valid), .temp_sample(temp_sample),
		.dyn_range_code(dyn_range_code), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data),
		.last_word(last_word), .word_cnt(word_cnt), .gap(gap));
	// compare within a tolerance; an unknown never matches
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g, input int tol);
		num_checks++;
		if ((g + tol >= x && g <= x + tol) !== 1'b1) begin
			error_cnt++;
			$display("Error %s expected %0d seen %0d", n, x, g);
		end
	endtask : chk
	// one apb transfer; waits for pready, leaves data in q and error in e
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
		chk("write error", 0, e, 0);
	endtask : wr
	// wait for n more words from the protocol stage; the hang guard
	// bounds the wait
	task automatic words(input int n);
		logic [31:0] c;
		c = word_cnt;
		while (word_cnt - c < n) begin
			@(posedge pclk);
		end
		y = last_word;
	endtask : words
	// program one setting, hold the field and compare the settled word
	task automatic rc(input logic [15:0] s, input logic [31:0] g, o, l,
		input logic [7:0] t, input logic [31:0] tl, tq, x);
		wr(hsd_pkg::ADDR_GAIN, g);
		wr(hsd_pkg::ADDR_OFFS, o);
		wr(hsd_pkg::ADDR_LIMIT, l);
		wr(hsd_pkg::ADDR_TC1, tl);
		wr(hsd_pkg::ADDR_TC2, tq);
		smp <= s;
		tmp <= t;
		words(24);
		chk("out_data", x, y, 0);
		apb(hsd_pkg::ADDR_STATUS, 1'b0, 32'h0);
		chk("status word", x, q[15:0], 0);
	endtask : rc
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	// hang guard: the whole run needs about 42000 cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 70000) begin
			error_cnt++;
			$display("Error run time expected end seen hang");
			finish_test();
		end
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			apb(8'(i * 4), 1'b0, 32'h0);
			chk("reset value", rv[i], q, 0);
		end
		apb(8'h24, 1'b0, 32'h0);
		chk("unmapped error", 1, e, 0);
		apb(hsd_pkg::ADDR_STATUS, 1'b1, 32'hffffffff);
		chk("status write error", 0, e, 0);
		for (int c = 0; c < 4; c++) begin
			wr(hsd_pkg::ADDR_RANGE, c);
			apb(hsd_pkg::ADDR_STATUS, 1'b0, 32'h0);
			chk("range", c == 2 ? 1 : c, range_select, 0);
			chk("status range", c == 2 ? 1 : c, q[17:16], 0);
		end
		wr(hsd_pkg::ADDR_RANGE, 32'h10);
		for (int c = 0; c < 4; c++) begin
			dyn <= 2'(c);
			apb(hsd_pkg::ADDR_STATUS, 1'b0, 32'h0);
			chk("dyn range", c == 2 ? 1 : c, range_select, 0);
		end
		wr(hsd_pkg::ADDR_RANGE, 32'h1);
		wr(hsd_pkg::ADDR_FILT, 32'h7);
		rc(16'h03e8, 32'h5000, 32'h4064, 32'h3f00, 8'h00, 32'ha0, 32'h80,
			32'h044c);
		rc(16'h03e8, 32'h6000, 32'h4064, 32'h3f00, 8'h00, 32'ha0, 32'h80,
			32'h0834);
		rc(16'hfc18, 32'h3000, 32'h4000, 32'h3f00, 8'h00, 32'ha0, 32'h80,
			32'h03e8);
		rc(16'h03e8, 32'h5000, 32'h0000, 32'h3f00, 8'h00, 32'ha0, 32'h80,
			32'h0000);
		rc(16'h7530, 32'h6000, 32'h7fff, 32'h3f00, 8'h00, 32'ha0, 32'h80,
			32'hffff);
		rc(16'h1900, 32'h5000, 32'h4000, 32'h3f00, 8'h10, 32'he0, 32'ha0,
			32'h196a);
		rc(16'h03e8, 32'h5000, 32'h4000, 32'h3f02, 8'h00, 32'ha0, 32'h80,
			32'h0800);
		rc(16'h7530, 32'h5000, 32'h4000, 32'h0500, 8'h00, 32'ha0, 32'h80,
			32'h17ff);
		rc(16'h03e8, 32'h5000, 32'h4000, 32'h020a, 8'h00, 32'ha0, 32'h80,
			32'h0bff);
		wr(hsd_pkg::ADDR_LIMIT, 32'h3f00);
		// first step after a jump reflects the cutoff of codes 0..6; code 7 passes the whole jump
		for (int c = 0; c < 8; c++) begin
			wr(hsd_pkg::ADDR_FILT, 32'h7);
			smp <= 16'h0000;
			words(24);
			wr(hsd_pkg::ADDR_FILT, c);
			smp <= 16'h3e80;
			for (int k = 0; k < 10 && (k == 0 || y == 16'h0); k++) begin
				words(1);
			end
			cnt = c == 7 ? 16000 : $rtoi(6.2832 * fc[c] + 0.5);
			chk("first step", cnt, y, c == 7 ? 0 : cnt / 32 + 2);
			words(200);
			chk("settled", 16000, y, 64);
		end
		chk("word gap", TICK, gap, 0);
		stall <= 1'b1;
		repeat (40 * TICK) @(posedge pclk);
		chk("held word", 1, out_valid, 0);
		cnt = word_cnt;
		stall <= 1'b0;
		repeat (40) @(posedge pclk);
		chk("burst", 19, word_cnt - cnt, 3);
		finish_test();
	end
endmodule : test_hsd_chain
